// >>> rtl/aprt_params.svh
// Purpose: Offsets, field positions, reset values and codes of the audio port router.
// Assumes: Eight-bit registers addressed by their byte offset.
// Notes:   Definitions only.
`ifndef APRT_PARAMS_SVH
`define APRT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define APRT_OFF_CLK_OUT   8'h2E
`define APRT_OFF_DATA_OUT  8'h2F
`define APRT_OFF_RSVD      8'h30
`define APRT_OFF_PAIR1     8'h31
`define APRT_OFF_PAIR2     8'h32
`define APRT_OFF_PAIR3     8'h33

// ----------------------------------------------------------------------------
// Reset values and field masks
// ----------------------------------------------------------------------------
`define APRT_RST_CLK_OUT   8'h40
`define APRT_RST_DATA_OUT  8'h00
`define APRT_RST_PAIR1     8'h01
`define APRT_RST_PAIR2     8'h00
`define APRT_RST_PAIR3     8'h00
`define APRT_MASK_DATA_OUT 8'h03
`define APRT_MASK_PAIR     8'h1F

// ----------------------------------------------------------------------------
// Selector codes
// ----------------------------------------------------------------------------
`define APRT_FCK_PLAY      4'h0
`define APRT_FCK_REC       4'h1
`define APRT_FCK_P1_DIV    4'h2
`define APRT_FCK_P1_IN     4'h3
`define APRT_FCK_P2_DIV    4'h4
`define APRT_FCK_P2_IN     4'h5
`define APRT_FCK_P3_DIV    4'h6
`define APRT_FCK_P1_REC    4'h8
`define APRT_FCK_P2_REC    4'h9
`define APRT_BCK_P3_DIV    4'h4
`define APRT_PAIR_NONE     5'h00
`define APRT_PAIR1_FIRST_PORT_DATA_IN    5'h01
`define APRT_PAIR2_GP2     5'h05
`define APRT_PAIR2_GP3     5'h06

// Avalon slave address width (byte offsets, bits above 8 must be zero).
`define APRT_AV_AW         4'h8

`endif

// >>> rtl/aprt_pkg.sv
// Purpose: Types shared by the router ends.
// Assumes: Nothing beyond the params header.
// Notes:   Controller sequencer states.
package aprt_pkg;

  typedef enum logic [1:0] {
    APRT_IDLE  = 2'b00,
    APRT_WRITE = 2'b01,
    APRT_READ  = 2'b10,
    APRT_DONE  = 2'b11
  } aprt_state_type;

  typedef logic [7:0] aprt_byte_type;

endpackage

// >>> rtl/aprt_if.sv
// Purpose: Register access link between router device and its controller.
// Assumes: Single core clock; one transfer at a time.
// Notes:   A request stands until ack pulses.
`timescale 1ns/10ps
interface aprt_if;
  logic       req;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;

  // Device end answers requests.
  modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
  // Controller end issues requests.
  modport ctl (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface // aprt_if

// >>> rtl/aprt_router.sv
// Contract
// (RULE_01) Frame out: playback 0000, record 0001.
// (RULE_02) Codes 0010-0110: divider and frame inputs.
// (RULE_03) Codes 1000/1001: port 1/2 record frame.
// (RULE_04) Software avoids frame codes 0111, 1010-1111.
// (RULE_05) Data select 00: own third-port serializer.
// (RULE_06) Data select 01-11: loop port data in.
// (RULE_07) Reserved bits read zero, write defaults.
// (RULE_08) Pair 1 code 00000 forces zeros.
// (RULE_09) Pair 1 resets to 00001: first data in.
// (RULE_10) Software avoids pair 1 codes 00010-11111.
// (RULE_11) Pair 2 multi-lane only; resets to none.
// (RULE_12) Pair 2 codes 00101/00110: general pins.
// (RULE_13) Software avoids reserved pair 2 codes.
// (RULE_14) Bit clock select resets to port 3 divider.
// (RULE_15) Routing follows register write immediately.
//
// Purpose: Register file and clock/data routing muxes of the third audio port.
// Assumes: Pin inputs are asynchronous and pass two flip-flops first.
// Notes:   Reserved selector codes drive low; outputs are registered.
//          A pin source reaches its output three cycles after it changes,
//          a same-clock source one cycle after.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
`include "aprt_params.svh"
module aprt_router (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Register link
  aprt_if.dev       bus,
  // On-chip frame clock sources
  input  wire logic playback_sample_rate_clock,
  input  wire logic record_sample_rate_clock,
  input  wire logic first_port_frame_divider_out,
  input  wire logic second_port_frame_divider_out,
  input  wire logic third_port_frame_divider_out,
  input  wire logic first_port_record_frame_clock,
  input  wire logic second_port_record_frame_clock,
  // Pin inputs
  input  wire logic first_port_frame_clock_in,
  input  wire logic second_port_frame_clock_in,
  input  wire logic first_port_data_in,
  input  wire logic second_port_data_in,
  input  wire logic third_port_data_in,
  input  wire logic general_pin_two,
  input  wire logic general_pin_three,
  // Bit clock sources
  input  wire logic [7:0] bit_clock_sources,
  // Serializer data
  input  wire logic third_port_serializer_out,
  // Routed outputs
  output logic      third_port_frame_clock_out,
  output logic      third_port_bit_clock_out,
  output logic      third_port_data_out,
  output logic      lane_pair_one,
  output logic      lane_pair_two
);
  import aprt_pkg::*;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  aprt_byte_type clk_sel_q;
  logic [1:0]    data_sel_q;
  logic [4:0]    pair1_sel_q;
  logic [4:0]    pair2_sel_q;
  logic [4:0]    pair3_sel_q;
  logic          ack_q;
  aprt_byte_type rdata_q;
  logic [6:0]    sync1_q;
  logic [6:0]    sync2_q;

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  // Lane bits of a written byte outside the field are dropped.
  function automatic logic [4:0] aprt_pair_field(input aprt_byte_type v);
    aprt_pair_field = v[4:0];
  endfunction

  // Register writes; each selector updates on the acking edge.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clk_sel_q   <= `APRT_RST_CLK_OUT; // RULE_14
      data_sel_q  <= 2'(`APRT_RST_DATA_OUT); // RULE_05
      pair1_sel_q <= aprt_pair_field(`APRT_RST_PAIR1); // RULE_09
      pair2_sel_q <= aprt_pair_field(`APRT_RST_PAIR2); // RULE_11
      pair3_sel_q <= aprt_pair_field(`APRT_RST_PAIR3);
    end else if (bus.req && bus.we && !ack_q) begin
      unique case (bus.addr)
        `APRT_OFF_CLK_OUT:  clk_sel_q   <= bus.wdata; // RULE_15
        `APRT_OFF_DATA_OUT: data_sel_q  <= bus.wdata[1:0]; // RULE_07
        `APRT_OFF_PAIR1:    pair1_sel_q <= aprt_pair_field(bus.wdata);
        `APRT_OFF_PAIR2:    pair2_sel_q <= aprt_pair_field(bus.wdata);
        `APRT_OFF_PAIR3:    pair3_sel_q <= aprt_pair_field(bus.wdata);
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  // One-cycle acknowledge and read data; reserved bits and slots read zero.
  // The acknowledge never stands two cycles running, since a request is
  // only taken while no acknowledge stands; a request held on is acked again.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= bus.req && !ack_q;
      if (bus.req && !bus.we && !ack_q) begin
        unique case (bus.addr)
          `APRT_OFF_CLK_OUT:  rdata_q <= clk_sel_q;
          `APRT_OFF_DATA_OUT: rdata_q <= {6'h00, data_sel_q}; // RULE_07
          `APRT_OFF_PAIR1:    rdata_q <= {3'h0, pair1_sel_q}; // RULE_07
          `APRT_OFF_PAIR2:    rdata_q <= {3'h0, pair2_sel_q};
          `APRT_OFF_PAIR3:    rdata_q <= {3'h0, pair3_sel_q};
          default:            rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Link outputs
  // --------------------------------------------------------------------------
  // Both answer signals come straight from their flip-flops.
  assign bus.ack   = ack_q;
  assign bus.rdata = rdata_q;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Two-stage synchronisers on every pin input.
  // Only the second stage feeds the muxes, so a metastable first stage
  // never reaches the routed outputs.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {general_pin_three, general_pin_two, third_port_data_in,
                  second_port_data_in, first_port_data_in,
                  second_port_frame_clock_in, first_port_frame_clock_in};
      sync2_q <= sync1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Routing muxes
  // --------------------------------------------------------------------------
  // Frame clock output select; reserved codes hold the output low.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      third_port_frame_clock_out <= 1'b0;
    end else begin
      unique case (clk_sel_q[3:0])
        `APRT_FCK_PLAY:   third_port_frame_clock_out <= playback_sample_rate_clock; // RULE_01
        `APRT_FCK_REC:    third_port_frame_clock_out <= record_sample_rate_clock; // RULE_01
        `APRT_FCK_P1_DIV: third_port_frame_clock_out <= first_port_frame_divider_out; // RULE_02
        `APRT_FCK_P1_IN:  third_port_frame_clock_out <= sync2_q[0]; // RULE_02
        `APRT_FCK_P2_DIV: third_port_frame_clock_out <= second_port_frame_divider_out; // RULE_02
        `APRT_FCK_P2_IN:  third_port_frame_clock_out <= sync2_q[1]; // RULE_02
        `APRT_FCK_P3_DIV: third_port_frame_clock_out <= third_port_frame_divider_out; // RULE_02
        `APRT_FCK_P1_REC: third_port_frame_clock_out <= first_port_record_frame_clock; // RULE_03
        `APRT_FCK_P2_REC: third_port_frame_clock_out <= second_port_record_frame_clock; // RULE_03
        default:          third_port_frame_clock_out <= 1'b0;
      endcase
    end
  end

  // Bit clock output select; codes above 7 are reserved.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      third_port_bit_clock_out <= 1'b0;
    end else begin
      // Code 4, the reset choice, picks the third port's own divider.
      third_port_bit_clock_out <= clk_sel_q[7] ? 1'b0 :
                                  bit_clock_sources[clk_sel_q[6:4]]; // RULE_14
    end
  end

  // Data output select: own serializer or pin-to-pin loopback.
  // Loopback paths carry the two-cycle delay of the synchronisers.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      third_port_data_out <= 1'b0;
    end else begin
      unique case (data_sel_q)
        2'h0: third_port_data_out <= third_port_serializer_out; // RULE_05
        2'h1: third_port_data_out <= sync2_q[2]; // RULE_06
        2'h2: third_port_data_out <= sync2_q[3]; // RULE_06
        2'h3: third_port_data_out <= sync2_q[4]; // RULE_06
      endcase
    end
  end

  // Stereo pair lanes; none and reserved codes give zero data.
  // Pair 3 is only stored here; its lane lies outside this block.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lane_pair_one <= 1'b0;
      lane_pair_two <= 1'b0;
    end else begin
      lane_pair_one <= (pair1_sel_q == `APRT_PAIR1_FIRST_PORT_DATA_IN) ? sync2_q[2] : 1'b0; // RULE_08 RULE_09
      unique case (pair2_sel_q)
        `APRT_PAIR2_GP2: lane_pair_two <= sync2_q[5]; // RULE_12
        `APRT_PAIR2_GP3: lane_pair_two <= sync2_q[6]; // RULE_12
        default:         lane_pair_two <= 1'b0;
      endcase
    end
  end

endmodule // aprt_router

// >>> rtl/aprt_ctl.sv
// Purpose: Controller end; Avalon-MM slave that forwards accesses to the router.
// Assumes: Avalon master holds a request until waitrequest is low.
// Notes:   Byte offsets map one register per aligned word; reserved frame and pair codes are replaced by reset values.
`timescale 1ns/10ps
`include "aprt_params.svh"
module aprt_ctl (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Router link
  aprt_if.ctl              lnk
);
  import aprt_pkg::*;

  aprt_state_type state_q;
  logic           req_q;
  logic           we_q;
  aprt_byte_type  addr_q;
  aprt_byte_type  wdata_q;

  // Replace reserved frame and pair selector codes by their reset value; bit clock codes pass unchanged.
  function automatic aprt_byte_type aprt_legal(input aprt_byte_type a, input aprt_byte_type d);
    aprt_legal = d;
    if (a == `APRT_OFF_CLK_OUT && (d[3:0] == 4'h7 || d[3:0] > 4'h9)) // RULE_04
      aprt_legal = {d[7:4], 4'h0};
    else if (a == `APRT_OFF_DATA_OUT)
      aprt_legal = d & `APRT_MASK_DATA_OUT; // RULE_07
    else if (a == `APRT_OFF_PAIR1 && d[4:0] > 5'h01) // RULE_10
      aprt_legal = `APRT_RST_PAIR1;
    else if (a == `APRT_OFF_PAIR2 && d[4:0] != 5'h05 && d[4:0] != 5'h06) // RULE_11 RULE_13
      aprt_legal = `APRT_RST_PAIR2;
    else if (a == `APRT_OFF_RSVD)
      aprt_legal = 8'h00;
  endfunction

  // Sequencer: take Avalon request, run one link transfer, release bus.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q         <= APRT_IDLE;
      req_q           <= 1'b0;
      we_q            <= 1'b0;
      addr_q          <= 8'h00;
      wdata_q         <= 8'h00;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      unique case (state_q)
        APRT_IDLE: begin
          avs_waitrequest <= 1'b1;
          if (avs_read || avs_write) begin
            req_q   <= 1'b1;
            we_q    <= avs_write;
            addr_q  <= {2'b00, avs_address[7:2]};
            wdata_q <= aprt_legal({2'b00, avs_address[7:2]}, avs_writedata[7:0]);
            state_q <= avs_write ? APRT_WRITE : APRT_READ;
          end
        end
        APRT_WRITE, APRT_READ: begin
          if (lnk.ack) begin
            req_q           <= 1'b0;
            avs_readdata    <= {24'h00_0000, we_q ? 8'h00 : lnk.rdata};
            avs_waitrequest <= 1'b0;
            state_q         <= APRT_DONE;
          end
        end
        APRT_DONE: begin
          avs_waitrequest <= 1'b1;
          state_q         <= APRT_IDLE;
        end
      endcase
    end
  end

  assign lnk.req   = req_q;
  assign lnk.we    = we_q;
  assign lnk.addr  = addr_q;
  assign lnk.wdata = wdata_q;

endmodule // aprt_ctl

// >>> sim/aprt_link_properties.sv
// Purpose: Checks the register link between router and controller.
// Assumes: One clock; rst is synchronous and active high.
// Notes:   Read-back codes are those left after the controller replaces reserved codes.
`timescale 1ns/10ps
module aprt_link_properties (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Link signals
  input wire logic       req,
  input wire logic       we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack
);
  // --------
  // Link checks
  // --------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // A read answer on the link.
  wire logic rd = ack && !we;
  ack_next_a: assert property (req && !ack |=> req && ack)
    else $error("link ack missing");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("link ack too long");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("link ack without request");
  data_rsvd_a: assert property (rd && addr == 8'h2F |-> rdata[7:2] == 6'h00)
    else $error("data select high bits set");
  wdata_rsvd_a: assert property (ack && we && addr == 8'h2F |-> wdata[7:2] == 6'h00)
    else $error("reserved data bits written");
  slot_zero_a: assert property (rd && addr == 8'h30 |-> rdata == 8'h00)
    else $error("reserved slot not zero");
  clk_code_a: assert property (rd && addr == 8'h2E |->
    rdata[3:0] != 4'h7 && rdata[3:0] < 4'hA)
    else $error("frame code reserved");
  pair1_code_a: assert property (rd && addr == 8'h31 |-> rdata[7:1] == 7'h00)
    else $error("pair one code reserved");
  pair2_code_a: assert property (rd && addr == 8'h32 |->
    rdata inside {8'h00, 8'h05, 8'h06})
    else $error("pair two code reserved");
  // Main traffic kinds.
  cover property (ack && we);
  cover property (rd && addr == 8'h32 && rdata == 8'h05);
  cover property (rd && addr == 8'h2E);
endmodule // aprt_link_properties

// >>> sim/aprt_tb.sv
// Purpose: Self-checking bench for the router and its controller.
// Assumes: Each Avalon access ends with one low waitrequest.
// Notes:   Routes are sampled five cycles after a source change, the reset bit clock route three.
`timescale 1ns/10ps
module aprt_tb;
  // Bench signals.
  logic        core_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_q;
  logic [14:0] src;
  logic [7:0]  bck;
  logic [4:0]  outs;
  logic [7:0]  rv [6] = '{8'h40, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  int          failures, n_compared;
  aprt_if u_aprt_if ();
  aprt_router u_aprt_router (.core_clk(core_clk), .rst(rst), .bus(u_aprt_if),
    .playback_sample_rate_clock(src[0]), .record_sample_rate_clock(src[1]),
    .first_port_frame_divider_out(src[2]), .first_port_frame_clock_in(src[3]),
    .second_port_frame_divider_out(src[4]), .second_port_frame_clock_in(src[5]),
    .third_port_frame_divider_out(src[6]), .first_port_record_frame_clock(src[7]),
    .second_port_record_frame_clock(src[8]), .third_port_serializer_out(src[9]),
    .first_port_data_in(src[10]), .second_port_data_in(src[11]),
    .third_port_data_in(src[12]), .general_pin_two(src[13]),
    .general_pin_three(src[14]), .bit_clock_sources(bck),
    .third_port_frame_clock_out(outs[0]), .third_port_bit_clock_out(outs[1]),
    .third_port_data_out(outs[2]), .lane_pair_one(outs[3]), .lane_pair_two(outs[4]));
  aprt_ctl u_aprt_ctl (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lnk(u_aprt_if));
  aprt_link_properties u_aprt_link_properties (.core_clk(core_clk), .rst(rst),
    .req(u_aprt_if.req), .we(u_aprt_if.we), .addr(u_aprt_if.addr),
    .wdata(u_aprt_if.wdata), .rdata(u_aprt_if.rdata), .ack(u_aprt_if.ack));

  // --------
  // Tasks
  // --------
  // Clock of 25 ns.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Counts a compare and reports a mismatch.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One Avalon access; the request stands until waitrequest is seen low.
  task automatic av(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      conclude();
    end
  endtask
  // Writes a selector, then drives source s high and low against output o.
  task automatic route(input logic [9:0] a, input logic [7:0] v, input int s, input int o,
                       input logic live);
    av(1'b1, a, {24'h000000, v});
    for (int k = 1; k >= 0; k--) begin
      src <= k ? 15'h0001 << s : ~(15'h0001 << s);
      repeat (5) @(posedge core_clk);
      check({31'h0, outs[o]}, {31'h0, live & k[0]});
    end
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 10'h000;
    avs_writedata = 32'h0;
    src = 15'h0000;
    bck = 8'h10;
    failures = 0;
    n_compared = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rv[i]) begin
      av(1'b0, 10'h0B8 + 10'(4 * i), 32'h0);
      check(rd_q, {24'h000000, rv[i]});
    end
    for (int k = 1; k >= 0; k--) begin
      bck <= k ? 8'h10 : 8'hEF;
      repeat (3) @(posedge core_clk);
      check({31'h0, outs[1]}, {31'h0, k[0]});
    end
    $display("test reset done");
    for (int c = 0; c < 10; c++)
      if (c != 7) route(10'h0B8, 8'h40 | 8'(c), c - (c > 7), 0, 1'b1);
    route(10'h0B8, 8'h4A, 0, 0, 1'b1);
    av(1'b0, 10'h0B8, 32'h0);
    check(rd_q, 32'h00000040);
    $display("test frame clock done");
    for (int c = 0; c < 4; c++) route(10'h0BC, 8'(c), 9 + c, 2, 1'b1);
    av(1'b1, 10'h0BC, 32'h000000FF);
    av(1'b0, 10'h0BC, 32'h0);
    check(rd_q, 32'h00000003);
    av(1'b1, 10'h0C0, 32'h000000FF);
    av(1'b0, 10'h0C0, 32'h0);
    check(rd_q, 32'h00000000);
    av(1'b0, 10'h3FC, 32'h0);
    check(rd_q, 32'h00000000);
    $display("test data out done");
    route(10'h0C4, 8'h00, 10, 3, 1'b0);
    route(10'h0C4, 8'h01, 10, 3, 1'b1);
    route(10'h0C8, 8'h05, 13, 4, 1'b1);
    route(10'h0C8, 8'h06, 14, 4, 1'b1);
    route(10'h0C8, 8'h02, 14, 4, 1'b0);
    av(1'b0, 10'h0C8, 32'h0);
    check(rd_q, 32'h00000000);
    av(1'b1, 10'h0C4, 32'h00000005);
    av(1'b0, 10'h0C4, 32'h0);
    check(rd_q, 32'h00000001);
    av(1'b1, 10'h0C8, 32'h0000001F);
    av(1'b0, 10'h0C8, 32'h0);
    check(rd_q, 32'h00000000);
    $display("test pairs done");
    conclude();
  end
endmodule // aprt_tb
